// File: core/acr_cal.sv
// Offset subtraction then full-scale scaling of conversion results
// Assumes: samples two's complement, same clock as the bank
`timescale 1ns/1ps
`default_nettype none
module acr_cal (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bank side
  acr_cal_if.cal cal
);
  // ==========================================================
  // Stage one: offset removal
  logic [24:0] diff_q, diff_d;
  logic v1_q, v1_d;
  logic [23:0] res_q, res_d;
  logic v2_q, v2_d;
  logic signed [49:0] prod;
  logic signed [49:0] scaled;

  always_comb begin
    v1_d = cal.sample_valid;
    diff_d = diff_q;
    if (cal.sample_valid) begin
      diff_d = 25'({cal.sample[23], cal.sample} -
                   {cal.offset_word[23], cal.offset_word});
    end
  end

  // ==========================================================
  // Stage two: scale by word over unity, saturate
  always_comb begin
    prod = $signed(diff_q) * $signed({1'b0, cal.gain_word});
    scaled = prod >>> acr_pkg::ACR_GAIN_SHIFT;
    v2_d = v1_q;
    res_d = res_q;
    if (v1_q) begin
      if (scaled > $signed(50'(signed'(acr_pkg::ACR_SAT_MAX)))) begin
        res_d = acr_pkg::ACR_SAT_MAX;
      end else if (scaled < 50'sd0 - 50'sd8388608) begin
        res_d = acr_pkg::ACR_SAT_MIN;
      end else begin
        res_d = scaled[23:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      diff_q <= 25'h0;
      v1_q <= 1'b0;
      res_q <= 24'h000000;
      v2_q <= 1'b0;
    end else begin
      diff_q <= diff_d;
      v1_q <= v1_d;
      res_q <= res_d;
      v2_q <= v2_d;
    end
  end

  assign cal.result = res_q;
  assign cal.result_valid = v2_q;

  // ==========================================================
  // Checks
  property p_cal_latency;
    @(posedge clk_i) disable iff (rst_i)
    cal.sample_valid |-> ##2 cal.result_valid;
  endproperty
  a_cal_latency: assert property (p_cal_latency)
    else $error("Corrected result not two cycles after sample");

  property p_cal_unity;
    @(posedge clk_i) disable iff (rst_i)
    (cal.sample_valid && cal.offset_word == 24'h000000 &&
     cal.gain_word == acr_pkg::ACR_GAIN_UNITY) ##1
    (cal.gain_word == acr_pkg::ACR_GAIN_UNITY)
    |-> ##1 cal.result == $past(cal.sample, 2);
  endproperty
  a_cal_unity: assert property (p_cal_unity)
    else $error("Unity gain and zero offset changed the sample");

endmodule : acr_cal
`default_nettype wire

// File: core/acr_cal_if.sv
// Carrier between register bank and calibration datapath
// Assumes: one clock domain, bank drives words and samples
`timescale 1ns/1ps
`default_nettype none
interface acr_cal_if;
  logic [23:0] offset_word;
  logic [23:0] gain_word;
  logic [23:0] sample;
  logic sample_valid;
  logic [23:0] result;
  logic result_valid;
  modport bank (
    output offset_word, gain_word, sample, sample_valid,
    input result, result_valid
  );
  modport cal (
    input offset_word, gain_word, sample, sample_valid,
    output result, result_valid
  );
endinterface : acr_cal_if
`default_nettype wire

// File: core/acr_pkg.sv
// Constants for the converter configuration and calibration register bank
// Assumes: 32-bit classic Wishbone, registers in data bits 7:0
`default_nettype none
package acr_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] ACR_IDX_PIN_ROUTE = 6'h04;
  localparam logic [5:0] ACR_IDX_MODE_THREE = 6'h05;
  localparam logic [5:0] ACR_IDX_REF_CFG = 6'h06;
  localparam logic [5:0] ACR_IDX_OFS_LOW = 6'h07;
  localparam logic [5:0] ACR_IDX_OFS_MID = 6'h08;
  localparam logic [5:0] ACR_IDX_OFS_HIGH = 6'h09;
  localparam logic [5:0] ACR_IDX_GAIN_LOW = 6'h0a;
  localparam logic [5:0] ACR_IDX_GAIN_MID = 6'h0b;
  localparam logic [5:0] ACR_IDX_GAIN_HIGH = 6'h0c;
  localparam int ACR_NREG = 9;
  // ==========================================================
  // Reset values, entry n sits at index ACR_IDX_PIN_ROUTE + n
  localparam logic [7:0] ACR_RST [ACR_NREG] = '{
    8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
  // ==========================================================
  // Field positions
  localparam int ACR_CONN_HI = 7;
  localparam int ACR_CONN_LO = 4;
  localparam int ACR_DIR_HI = 3;
  localparam int ACR_DIR_LO = 0;
  localparam int ACR_SOFT_POWER_DOWN_BIT = 7;
  localparam int ACR_STAT_BIT = 6;
  localparam int ACR_CRC_BIT = 5;
  localparam int ACR_AUTORST_BIT = 4;
  localparam int ACR_DAT_HI = 3;
  localparam int ACR_DAT_LO = 0;
  localparam int ACR_REFEN_BIT = 4;
  localparam int ACR_RPOS_HI = 3;
  localparam int ACR_RPOS_LO = 2;
  localparam int ACR_RNEG_HI = 1;
  localparam int ACR_RNEG_LO = 0;
  // ==========================================================
  // Reference source encodings
  localparam logic [1:0] ACR_RPOS_INTERNAL = 2'h0;
  localparam logic [1:0] ACR_RPOS_ANALOG_SUPPLY = 2'h1;
  localparam logic [1:0] ACR_RPOS_EXT_IN0 = 2'h2;
  localparam logic [1:0] ACR_RPOS_EXT_IN2 = 2'h3;
  localparam logic [1:0] ACR_RNEG_INTERNAL = 2'h0;
  localparam logic [1:0] ACR_RNEG_ANALOG_GROUND = 2'h1;
  localparam logic [1:0] ACR_RNEG_EXT_IN1 = 2'h2;
  localparam logic [1:0] ACR_RNEG_EXT_IN3 = 2'h3;
  // ==========================================================
  // Calibration arithmetic
  localparam int ACR_GAIN_SHIFT = 22;
  localparam logic [23:0] ACR_GAIN_UNITY = 24'h400000;
  localparam logic [23:0] ACR_SAT_MAX = 24'h7fffff;
  localparam logic [23:0] ACR_SAT_MIN = 24'h800000;
endpackage : acr_pkg
`default_nettype wire

// File: core/acr_regs.sv
// Configuration and calibration register bank of a delta-sigma converter
// Assumes: classic Wishbone master on clk_i, pins sampled from outside
//
// Summary of operation
// - Route bits 7:4 connect pins to analog inputs
// - Route bits 3:0 set pin direction, 0 output
// - Mode three bits 3:0 drive and read pins
// - Mode three bit 7 selects software power-down
// - Mode three bit 6 adds status byte
// - Mode three bit 5 enables check code
// - Mode three bit 4 enables serial auto-reset
// - Reference bit 4 turns internal reference on
// - Reference bits 3:2 pick positive source
// - Reference bits 1:0 pick negative source
// - Three offset bytes form 24-bit word, low first
// - Offset word subtracted as two's complement
// - Three gain bytes, top byte resets 40h
// - Result scaled by gain word over 400000h
`timescale 1ns/1ps
`default_nettype none
module acr_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // General pins
  input wire logic [3:0] pin_level_i,
  output logic [3:0] pin_level_o,
  output logic [3:0] pin_level_oe_o,
  output logic [3:0] pin_analog_connect_o,
  // Mode controls
  output logic soft_power_down_o,
  output logic status_byte_enable_o,
  output logic check_code_enable_o,
  output logic serial_auto_reset_enable_o,
  // Reference controls
  output logic internal_ref_enable_o,
  output logic [1:0] ref_positive_select_o,
  output logic [1:0] ref_negative_select_o,
  // Conversion data
  input wire logic [23:0] conv_data_i,
  input wire logic conv_valid_i,
  output logic [23:0] cal_data_o,
  output logic cal_valid_o
);
  // ==========================================================
  // Bus decode
  logic [5:0] idx;
  logic req;
  logic wr;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] reg_q [acr_pkg::ACR_NREG];
  logic [3:0] oe_q, oe_d;
  logic [3:0] sync1_q, sync2_q;
  acr_cal_if cif ();

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];

  // ==========================================================
  // Register storage, one entry per index
  genvar g;
  generate
    for (g = 0; g < acr_pkg::ACR_NREG; g++) begin : g_reg
      logic [7:0] d;
      always_comb begin
        d = reg_q[g];
        if (wr && idx == 6'(acr_pkg::ACR_IDX_PIN_ROUTE + 6'(g))) begin
          d = wb_dat_i[7:0];
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          reg_q[g] <= acr_pkg::ACR_RST[g];
        end else begin
          reg_q[g] <= d;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Pin input synchroniser and output enables
  always_comb begin
    oe_d = oe_q;
    if (wr && idx == acr_pkg::ACR_IDX_PIN_ROUTE) begin
      oe_d = ~wb_dat_i[acr_pkg::ACR_DIR_HI:acr_pkg::ACR_DIR_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_q <= ~acr_pkg::ACR_RST[0][acr_pkg::ACR_DIR_HI:acr_pkg::ACR_DIR_LO];
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      oe_q <= oe_d;
      sync1_q <= pin_level_i;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // Read mux and acknowledge
  function automatic logic [7:0] rd_byte(input logic [5:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i >= acr_pkg::ACR_IDX_PIN_ROUTE && i <= acr_pkg::ACR_IDX_GAIN_HIGH) begin
      v = reg_q[4'(i - acr_pkg::ACR_IDX_PIN_ROUTE)];
    end
    if (i == acr_pkg::ACR_IDX_MODE_THREE) begin
      // Input pins show the pin level, output pins the driven level
      v[acr_pkg::ACR_DAT_HI:acr_pkg::ACR_DAT_LO] =
        (sync2_q & ~oe_q) | (v[acr_pkg::ACR_DAT_HI:acr_pkg::ACR_DAT_LO] & oe_q);
    end
    return v;
  endfunction

  always_comb begin
    ack_d = req;
    rdat_d = 32'h00000000;
    if (req && !wb_we_i) begin
      rdat_d = {24'h000000, rd_byte(idx)};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ==========================================================
  // Calibration datapath
  assign cif.offset_word = {reg_q[5], reg_q[4], reg_q[3]};
  assign cif.gain_word = {reg_q[8], reg_q[7], reg_q[6]};
  assign cif.sample = conv_data_i;
  assign cif.sample_valid = conv_valid_i;

  acr_cal u_cal (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cal(cif.cal)
  );

  // ==========================================================
  // Outputs
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pin_analog_connect_o = reg_q[0][acr_pkg::ACR_CONN_HI:acr_pkg::ACR_CONN_LO];
  assign pin_level_oe_o = oe_q;
  assign pin_level_o = reg_q[1][acr_pkg::ACR_DAT_HI:acr_pkg::ACR_DAT_LO];
  assign soft_power_down_o = reg_q[1][acr_pkg::ACR_SOFT_POWER_DOWN_BIT];
  assign status_byte_enable_o = reg_q[1][acr_pkg::ACR_STAT_BIT];
  assign check_code_enable_o = reg_q[1][acr_pkg::ACR_CRC_BIT];
  assign serial_auto_reset_enable_o = reg_q[1][acr_pkg::ACR_AUTORST_BIT];
  assign internal_ref_enable_o = reg_q[2][acr_pkg::ACR_REFEN_BIT];
  assign ref_positive_select_o = reg_q[2][acr_pkg::ACR_RPOS_HI:acr_pkg::ACR_RPOS_LO];
  assign ref_negative_select_o = reg_q[2][acr_pkg::ACR_RNEG_HI:acr_pkg::ACR_RNEG_LO];
  assign cal_data_o = cif.result;
  assign cal_valid_o = cif.result_valid;

  // ==========================================================
  // Checks
  property p_connect;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == acr_pkg::ACR_IDX_PIN_ROUTE) |=>
      pin_analog_connect_o == $past(wb_dat_i[7:4]);
  endproperty
  a_connect: assert property (p_connect)
    else $error("Analog connect does not follow route write");

  property p_dir;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == acr_pkg::ACR_IDX_PIN_ROUTE) |=>
      pin_level_oe_o == ~$past(wb_dat_i[3:0]);
  endproperty
  a_dir: assert property (p_dir)
    else $error("Output enable not inverse of direction");

  property p_pin_out;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == acr_pkg::ACR_IDX_MODE_THREE) |=>
      pin_level_o == $past(wb_dat_i[3:0]);
  endproperty
  a_pin_out: assert property (p_pin_out)
    else $error("Pin level does not follow data write");

  property p_pin_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && idx == acr_pkg::ACR_IDX_MODE_THREE && oe_q == 4'h0)
      |=> wb_ack_o && wb_dat_o[3:0] == $past(sync2_q);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("Input pin read does not return pin level");

  property p_soft_power_down;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == acr_pkg::ACR_IDX_MODE_THREE) |=>
      soft_power_down_o == $past(wb_dat_i[7]) &&
      status_byte_enable_o == $past(wb_dat_i[6]);
  endproperty
  a_soft_power_down: assert property (p_soft_power_down)
    else $error("Power-down or status enable wrong after write");

  property p_modes;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == acr_pkg::ACR_IDX_MODE_THREE) |=>
      check_code_enable_o == $past(wb_dat_i[5]) &&
      serial_auto_reset_enable_o == $past(wb_dat_i[4]);
  endproperty
  a_modes: assert property (p_modes)
    else $error("Check code or auto-reset enable wrong after write");

  property p_ref;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == acr_pkg::ACR_IDX_REF_CFG) |=>
      internal_ref_enable_o == $past(wb_dat_i[4]) &&
      ref_positive_select_o == $past(wb_dat_i[3:2]) &&
      ref_negative_select_o == $past(wb_dat_i[1:0]);
  endproperty
  a_ref: assert property (p_ref)
    else $error("Reference controls wrong after write");

  property p_reset_vals;
    @(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> cif.gain_word == acr_pkg::ACR_GAIN_UNITY &&
      cif.offset_word == 24'h000000 &&
      ref_positive_select_o == acr_pkg::ACR_RPOS_ANALOG_SUPPLY &&
      ref_negative_select_o == acr_pkg::ACR_RNEG_ANALOG_GROUND &&
      !internal_ref_enable_o && !soft_power_down_o &&
      !status_byte_enable_o && !check_code_enable_o && !serial_auto_reset_enable_o &&
      pin_analog_connect_o == 4'h0 && pin_level_o == 4'h0 &&
      pin_level_oe_o == 4'hf;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Reset values wrong after reset release");

  property p_ofs_byte;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == acr_pkg::ACR_IDX_OFS_HIGH) |=>
      cif.offset_word[23:16] == $past(wb_dat_i[7:0]);
  endproperty
  a_ofs_byte: assert property (p_ofs_byte)
    else $error("Offset high byte not in bits 23:16");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !ack_q) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("Acknowledge not a single cycle after request");

  property p_ack_quiet;
    @(posedge clk_i) disable iff (rst_i)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_quiet: assert property (p_ack_quiet)
    else $error("Acknowledge without a request");

  property p_gain_byte;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == acr_pkg::ACR_IDX_GAIN_LOW) |=>
      cif.gain_word[7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_gain_byte: assert property (p_gain_byte)
    else $error("Gain low byte not in bits 7:0");

  property p_sel_ignored;
    @(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && !wb_sel_i[0]) |=>
      $stable(cif.offset_word) && $stable(cif.gain_word) && $stable(pin_level_oe_o);
  endproperty
  a_sel_ignored: assert property (p_sel_ignored)
    else $error("Write without byte select changed a register");

  property p_unmapped;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && (idx < acr_pkg::ACR_IDX_PIN_ROUTE ||
     idx > acr_pkg::ACR_IDX_GAIN_HIGH)) |=> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped read returned nonzero data");

  property p_pin_read_out;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && idx == acr_pkg::ACR_IDX_MODE_THREE && oe_q == 4'hf)
      |=> wb_dat_o[3:0] == $past(pin_level_o);
  endproperty
  a_pin_read_out: assert property (p_pin_read_out)
    else $error("Output pin read does not return driven level");

endmodule : acr_regs
`default_nettype wire

// File: verif/acr_pin_model.sv
// Model of the board around the four general pins
// Assumes: outside circuitry drives ext_i onto pins the bank releases
`timescale 1ns/1ps
`default_nettype none
module acr_pin_model (
  // Design side
  input wire logic [3:0] level_i,
  input wire logic [3:0] oe_i,
  // Outside world
  input wire logic [3:0] ext_i,
  output logic [3:0] pin_o
);
  // Driven pins show the bank's level, released pins the outside level
  assign pin_o = (level_i & oe_i) | (ext_i & ~oe_i);
endmodule : acr_pin_model
`default_nettype wire

// File: verif/adc_config_calib_regs_test.sv
// Self-checking bench for the converter register bank
// Assumes: acr_regs on classic Wishbone, acr_pin_model on the pins
`timescale 1ns/1ps
`default_nettype none
module adc_config_calib_regs_test;
  // ==========================================================
  // Signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] pin_level_i, pin_level_o, pin_level_oe_o, pin_analog_connect_o;
  logic [3:0] pin_ext = 4'h0;
  logic soft_power_down_o, status_byte_enable_o, check_code_enable_o;
  logic serial_auto_reset_enable_o, internal_ref_enable_o;
  logic [1:0] ref_positive_select_o, ref_negative_select_o;
  logic [23:0] conv_data_i = 24'h0;
  logic [23:0] cal_data_o;
  logic conv_valid_i = 1'b0;
  logic cal_valid_o;
  logic [1:0] vpipe = 2'h0;
  logic [23:0] expq [$];
  logic [7:0] shadow [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [7:0] v;
  logic [5:0] idx;
  logic [3:0] sel;
  logic [23:0] ofs, gain;
  logic [23:0] xs [6];

  always #2.5 clk_i = ~clk_i;

  acr_regs acr_regs_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_level_i(pin_level_i),
    .pin_level_o(pin_level_o), .pin_level_oe_o(pin_level_oe_o),
    .pin_analog_connect_o(pin_analog_connect_o), .soft_power_down_o(soft_power_down_o),
    .status_byte_enable_o(status_byte_enable_o), .check_code_enable_o(check_code_enable_o),
    .serial_auto_reset_enable_o(serial_auto_reset_enable_o),
    .internal_ref_enable_o(internal_ref_enable_o),
    .ref_positive_select_o(ref_positive_select_o),
    .ref_negative_select_o(ref_negative_select_o), .conv_data_i(conv_data_i),
    .conv_valid_i(conv_valid_i), .cal_data_o(cal_data_o), .cal_valid_o(cal_valid_o));

  acr_pin_model acr_pin_model_inst (
    .level_i(pin_level_o), .oe_i(pin_level_oe_o), .ext_i(pin_ext), .pin_o(pin_level_i));

  // ==========================================================
  // Checking helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  function automatic logic [31:0] exp_reg(input logic [5:0] i);
    logic [3:0] dir;
    dir = shadow[4][3:0];
    if (i < 6'h04 || i > 6'h0c) return 32'h0;
    if (i == 6'h05) return {24'h0, shadow[5][7:4], (shadow[5][3:0] & ~dir) | (pin_ext & dir)};
    return {24'h0, shadow[i]};
  endfunction : exp_reg

  // Offset subtracted, gain over 400000h, saturated to 24 bits
  function automatic logic [23:0] cal_exp(input logic [23:0] x, o, g);
    longint d, p;
    d = longint'(signed'(x)) - longint'(signed'(o));
    p = (d * longint'(g)) >>> 22;
    if (p > 64'sh7fffff) return 24'h7fffff;
    if (p < -64'sh800000) return 24'h800000;
    return p[23:0];
  endfunction : cal_exp

  // ==========================================================
  // Bus cycles
  task automatic wb(input logic we, input logic [5:0] i, input logic [7:0] wd,
      input logic [3:0] s, output logic [31:0] rdat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'($urandom), wd};
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    wb(1'b1, i, d, 4'hf, rd);
    if (i >= 6'h04 && i <= 6'h0c) shadow[i] = d;
  endtask : wr

  task automatic rchk(input logic [5:0] i);
    wb(1'b0, i, 8'h00, 4'hf, rd);
    chk($sformatf("register %0d", i), exp_reg(i), rd);
  endtask : rchk

  task automatic chk_outs();
    chk("route", {shadow[4][7:4], ~shadow[4][3:0]}, {pin_analog_connect_o, pin_level_oe_o});
    chk("mode three", shadow[5], {soft_power_down_o, status_byte_enable_o,
      check_code_enable_o, serial_auto_reset_enable_o, pin_level_o});
    chk("reference", shadow[6][4:0], {internal_ref_enable_o, ref_positive_select_o,
      ref_negative_select_o});
  endtask : chk_outs

  // ==========================================================
  // Result checking and timeout
  always @(posedge clk_i) begin
    vpipe <= rst_i ? 2'h0 : {vpipe[0], conv_valid_i};
    if (!rst_i && (vpipe[1] || cal_valid_o)) begin
      chk("result strobe", {31'h0, vpipe[1]}, {31'h0, cal_valid_o});
      if (vpipe[1] && expq.size() > 0) chk("result", expq.pop_front(), cal_data_o);
    end
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h6c63));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_outs();
    for (int i = 0; i < 16; i++) rchk(6'(i));
    for (int c = 0; c < 4; c++) begin
      wr(6'h06, {3'h0, c[0], c[1:0], 2'(3 - c)});
      chk_outs();
    end
    // All pins inputs, read back the outside level
    pin_ext <= 4'h9;
    wr(6'h04, 8'h3f);
    repeat (3) @(posedge clk_i);
    rchk(6'h05);
    for (int i = 0; i < 60; i++) begin
      idx = 6'($urandom_range(15, 2));
      v = 8'($urandom);
      if (idx == 6'h06) v[7:5] = 3'h0;
      sel = 4'($urandom);
      wb(1'b1, idx, v, sel, rd);
      if (sel[0] && idx >= 6'h04 && idx <= 6'h0c) shadow[idx] = v;
      pin_ext <= 4'($urandom);
      repeat (3) @(posedge clk_i);
      chk_outs();
      rchk(idx);
    end
    for (int k = 0; k < 3; k++) begin
      ofs = (k == 0) ? 24'h0 : 24'($urandom);
      gain = (k == 0) ? 24'h400000 : (k == 1) ? 24'($urandom) : 24'hffffff;
      for (int b = 0; b < 3; b++) begin
        wr(6'(7 + b), ofs[8*b +: 8]);
        wr(6'(10 + b), gain[8*b +: 8]);
      end
      xs = '{24'h7fffff, 24'h800000, 24'h0, 24'($urandom), 24'($urandom), 24'h000001};
      foreach (xs[j]) begin
        @(posedge clk_i);
        conv_valid_i <= 1'b1;
        conv_data_i <= xs[j];
        expq.push_back(cal_exp(xs[j], ofs, gain));
      end
      @(posedge clk_i);
      conv_valid_i <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
    chk("results left", 32'h0, 32'(expq.size()));
    final_report();
  end
endmodule : adc_config_calib_regs_test
`default_nettype wire
